// File: hw/vchi_defines.vh
// Constants of the codec host command interface: offsets, fields, resets, timing.
// Assumes a 32-bit register port addressed by byte offset, word aligned.
`ifndef VCHI_DEFINES_VH
`define VCHI_DEFINES_VH

// Control group
`define VCHI_OFF_CTRL 8'h00
`define VCHI_OFF_STATUS 8'h04
`define VCHI_OFF_IRQ_STAT 8'h08
`define VCHI_OFF_IRQ_MASK 8'h0c
`define VCHI_OFF_BOOT_ADDR 8'h10
`define VCHI_OFF_ENGINE_ID 8'h14
// Global group
`define VCHI_OFF_WORK_BASE 8'h20
`define VCHI_OFF_STRM_BASE 8'h24
`define VCHI_OFF_STRM_SIZE 8'h28
`define VCHI_OFF_STRM_WPTR 8'h2c
`define VCHI_OFF_STRM_RPTR 8'h30
`define VCHI_OFF_FRM_BASE 8'h34
`define VCHI_OFF_GLOBAL_OPT 8'h38
// Command group
`define VCHI_OFF_CMD 8'h40
`define VCHI_OFF_CMD_INST 8'h44
`define VCHI_OFF_CMD_STD 8'h48
`define VCHI_OFF_ARG0 8'h50

// Control fields
`define VCHI_CTRL_RUN 0
`define VCHI_CTRL_SOFT_RST 1
// Status fields
`define VCHI_ST_BUSY 0
`define VCHI_ST_RUNNING 1
`define VCHI_ST_MPEG1 2
`define VCHI_ST_ERR 3
`define VCHI_ST_INST_LSB 8
`define VCHI_ST_OPEN_LSB 16
// Interrupt status fields
`define VCHI_IRQ_DONE 0
`define VCHI_IRQ_ERR 1
`define VCHI_IRQ_STRM_EMPTY 2

// Command codes
`define VCHI_CMD_OPEN 8'h01
`define VCHI_CMD_CLOSE 8'h02
`define VCHI_CMD_PIC_RUN 8'h03
`define VCHI_CMD_SET_PARAM 8'h04
`define VCHI_CMD_GET_INFO 8'h05

// Codec standard codes, sequential from zero
`define VCHI_STD_ZERO 3'h0
`define VCHI_STD_MPEG2 3'h4
`define VCHI_STD_LAST 3'h7

// Flag in arg0 selecting MPEG-1 through the MPEG-2 path
`define VCHI_ARG_MPEG1 0

// Reset values
`define VCHI_RST_WORD 32'h0000_0000
`define VCHI_RST_MASK 3'h0

// Frame processing time
`define VCHI_FRAME_US 100
`define VCHI_CLK_MHZ 20
`define VCHI_FRAME_CYC (`VCHI_FRAME_US * `VCHI_CLK_MHZ)
`define VCHI_SHORT_CYC 4

`endif

// File: hw/vchi_frame_engine.v
// Frame engine stand-in: runs one operation to completion on its own counter.
// Assumes start is a one-cycle pulse given only while idle.
`timescale 1ns/10ps
module vchi_frame_engine #(
  parameter CW = 20
) (
  input wire sys_clk,
  input wire rst_n,
  input wire start,
  input wire [CW-1:0] cycles,
  output reg busy_q,
  output reg done_q
);
  reg [CW-1:0] cnt_q;

  // No register traffic needed while a frame runs; count alone ends it
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= {CW{1'b0}};
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q <= cycles;
      end else if (busy_q) begin
        if (cnt_q <= {{(CW-1){1'b0}}, 1'b1}) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // vchi_frame_engine

// File: hw/vchi_host_if.v
// Host command interface of the frame video codec: register bank, command
// sequencer, instance table, stream buffer pointers and completion interrupt.
// Assumes a single-master register port with one-cycle strobes, no wait.
//
// Contract
// - Bulk data only via shared memory
// - Commands and replies via register bank
// - Status registers readable apart from commands
// - Buffers one writer, pointer pair coordinates
// - Working region reserved for device only
// - Device owns frame buffers exclusively
// - Stream pointers and size always readable
// - Control registers show sequencer, boot init
// - Global registers survive instance switch
// - Command I/O overwritten on each command; only VCHI_CMD_GET_INFO overwrites args 0 and 1 here
// - Completion raises interrupt before result read
// - Frame completes without host register traffic
// - Buffer addresses are 32-bit physical
// - Standard codes zero to seven sequential
// - MPEG-1 decoded via MPEG-2 path
// - Concurrent instances by handle, close one
`timescale 1ns/10ps
`include "vchi_defines.vh"
module vchi_host_if #(
  parameter NINST = 4,
  parameter NARG = 4,
  parameter FRAME_CYC = `VCHI_FRAME_CYC,
  parameter [31:0] ENGINE_ID = 32'h0000_0a5e
) (
  input wire sys_clk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_q,
  output wire irq,
  output reg [31:0] mem_base_q,
  output reg [31:0] frm_base_q,
  output reg [2:0] codec_standard_select,
  output wire engine_busy
);
  // ENGINE_ID value is arbitrary

  localparam ST_IDLE = 3'b001;
  localparam ST_RUN = 3'b010;
  localparam ST_DONE = 3'b100;
  localparam CW = 20;
  localparam [CW-1:0] SHORT_CYC = `VCHI_SHORT_CYC;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  reg [2:0] state_q;
  reg [1:0] ctrl_q;
  reg [31:0] boot_addr_q;
  reg [31:0] work_base_q;
  reg [31:0] strm_base_q;
  reg [31:0] strm_size_q;
  reg [31:0] strm_wptr_q;
  reg [31:0] strm_rptr_q;
  reg [31:0] global_opt_q;
  reg [7:0] cmd_q;
  reg [7:0] inst_q;
  reg [2:0] std_q;
  reg [31:0] arg_q [0:NARG-1];
  reg [NINST-1:0] open_q;
  reg [2:0] inst_std_q [0:NINST-1];
  reg [2:0] irq_stat_q;
  reg [2:0] irq_mask_q;
  reg busy_q;
  reg err_q;
  reg mpeg1_q;
  reg eng_start_q;
  reg [CW-1:0] eng_cycles_q;
  wire eng_busy;
  wire eng_done;

  integer i;
  integer j;

  wire wr_cmd = reg_wr && (reg_addr == `VCHI_OFF_CMD);
  wire rd_irq = reg_rd && (reg_addr == `VCHI_OFF_IRQ_STAT);
  wire [1:0] sel_inst = inst_q[1:0];
  wire inst_ok = (inst_q < NINST);
  wire [31:0] arg_idx = ({24'h0, reg_addr} - {24'h0, `VCHI_OFF_ARG0}) >> 2;
  wire arg_hit = (reg_addr >= `VCHI_OFF_ARG0) && (arg_idx < NARG) && (reg_addr[1:0] == 2'b00);
  wire strm_empty = (strm_wptr_q == strm_rptr_q);

  ////////////////////////////////////////////////////////////////////////
  // Frame engine
  vchi_frame_engine #(.CW(CW)) u_eng (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(eng_start_q),
    .cycles(eng_cycles_q),
    .busy_q(eng_busy),
    .done_q(eng_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Command sequencer
  // Events raised in the cycle the status is read still stick
  wire [2:0] irq_set = {strm_empty & (state_q == ST_DONE) & (cmd_q == `VCHI_CMD_PIC_RUN),
                        (state_q == ST_DONE) & err_q, (state_q == ST_DONE)};

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      busy_q <= 1'b0;
      err_q <= 1'b0;
      mpeg1_q <= 1'b0;
      cmd_q <= 8'h00;
      open_q <= {NINST{1'b0}};
      eng_start_q <= 1'b0;
      eng_cycles_q <= {CW{1'b0}};
      irq_stat_q <= `VCHI_RST_MASK;
      strm_rptr_q <= `VCHI_RST_WORD;
      for (i = 0; i < NINST; i = i + 1) begin
        inst_std_q[i] <= 3'h0;
      end
    end else begin
      eng_start_q <= 1'b0;
      irq_stat_q <= (rd_irq ? 3'h0 : irq_stat_q) | irq_set;
      if (ctrl_q[`VCHI_CTRL_SOFT_RST]) begin
        state_q <= ST_IDLE;
        busy_q <= 1'b0;
        open_q <= {NINST{1'b0}};
      end else begin
        case (state_q)
          ST_IDLE: begin
            // Commands refused until boot run bit set
            if (wr_cmd && ctrl_q[`VCHI_CTRL_RUN]) begin
              cmd_q <= reg_wdata[7:0];
              busy_q <= 1'b1;
              err_q <= 1'b0;
              state_q <= ST_RUN;
              eng_start_q <= 1'b1;
              eng_cycles_q <= (reg_wdata[7:0] == `VCHI_CMD_PIC_RUN) ?
                              FRAME_CYC[CW-1:0] : SHORT_CYC;
            end
          end
          ST_RUN: begin
            if (eng_done) begin
              state_q <= ST_DONE;
              case (cmd_q)
                `VCHI_CMD_OPEN: begin
                  if (!inst_ok || open_q[sel_inst]) begin
                    err_q <= 1'b1;
                  end else begin
                    open_q[sel_inst] <= 1'b1;
                    inst_std_q[sel_inst] <= std_q;
                    mpeg1_q <= (std_q == `VCHI_STD_MPEG2) && arg_q[0][`VCHI_ARG_MPEG1];
                  end
                end
                `VCHI_CMD_CLOSE: begin
                  if (!inst_ok || !open_q[sel_inst]) begin
                    err_q <= 1'b1;
                  end else begin
                    open_q[sel_inst] <= 1'b0;
                  end
                end
                `VCHI_CMD_PIC_RUN: begin
                  if (!inst_ok || !open_q[sel_inst]) begin
                    err_q <= 1'b1;
                  end else begin
                    strm_rptr_q <= strm_wptr_q;
                  end
                end
                `VCHI_CMD_SET_PARAM, `VCHI_CMD_GET_INFO: begin
                  err_q <= !inst_ok;
                end
                default: begin
                  err_q <= 1'b1;
                end
              endcase
            end
          end
          ST_DONE: begin
            busy_q <= 1'b0;
            state_q <= ST_IDLE;
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);
  assign engine_busy = busy_q;

  ////////////////////////////////////////////////////////////////////////
  // Host writes
  // Globals are never touched by instance switches
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= 2'b00;
      boot_addr_q <= `VCHI_RST_WORD;
      work_base_q <= `VCHI_RST_WORD;
      strm_base_q <= `VCHI_RST_WORD;
      strm_size_q <= `VCHI_RST_WORD;
      strm_wptr_q <= `VCHI_RST_WORD;
      frm_base_q <= `VCHI_RST_WORD;
      global_opt_q <= `VCHI_RST_WORD;
      irq_mask_q <= `VCHI_RST_MASK;
      inst_q <= 8'h00;
      std_q <= `VCHI_STD_ZERO;
      for (j = 0; j < NARG; j = j + 1) begin
        arg_q[j] <= `VCHI_RST_WORD;
      end
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          `VCHI_OFF_CTRL: ctrl_q <= reg_wdata[1:0];
          `VCHI_OFF_BOOT_ADDR: boot_addr_q <= reg_wdata;
          `VCHI_OFF_IRQ_MASK: irq_mask_q <= reg_wdata[2:0];
          // Base addresses are physical
          `VCHI_OFF_WORK_BASE: if (!busy_q) work_base_q <= reg_wdata;
          `VCHI_OFF_STRM_BASE: strm_base_q <= reg_wdata;
          `VCHI_OFF_STRM_SIZE: strm_size_q <= reg_wdata;
          `VCHI_OFF_STRM_WPTR: strm_wptr_q <= reg_wdata;
          `VCHI_OFF_FRM_BASE: if (!busy_q) frm_base_q <= reg_wdata;
          `VCHI_OFF_GLOBAL_OPT: global_opt_q <= reg_wdata;
          // Command I/O frozen while a command runs
          `VCHI_OFF_CMD_INST: if (!busy_q) inst_q <= reg_wdata[7:0];
          `VCHI_OFF_CMD_STD: if (!busy_q) std_q <= reg_wdata[2:0];
          default: begin
          end
        endcase
        if (arg_hit && !busy_q) begin
          arg_q[arg_idx] <= reg_wdata;
        end
      end
      // VCHI_CMD_GET_INFO results overwrite arguments 0 and 1 at completion
      if (state_q == ST_RUN && eng_done && cmd_q == `VCHI_CMD_GET_INFO && inst_ok) begin
        arg_q[0] <= {29'h0, inst_std_q[sel_inst]};
        arg_q[1] <= strm_size_q;
      end
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_base_q <= `VCHI_RST_WORD;
      codec_standard_select <= `VCHI_STD_ZERO;
    end else begin
      mem_base_q <= work_base_q;
      if (inst_ok) begin
        codec_standard_select <= inst_std_q[sel_inst];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Host reads: one cycle later; unmapped reads zero
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0;
    case (reg_addr)
      `VCHI_OFF_CTRL: rd_d = {30'h0, ctrl_q};
      `VCHI_OFF_STATUS: begin
        rd_d[`VCHI_ST_BUSY] = busy_q;
        rd_d[`VCHI_ST_RUNNING] = eng_busy;
        rd_d[`VCHI_ST_MPEG1] = mpeg1_q;
        rd_d[`VCHI_ST_ERR] = err_q;
        rd_d[`VCHI_ST_INST_LSB +: 8] = inst_q;
        rd_d[`VCHI_ST_OPEN_LSB +: NINST] = open_q;
      end
      `VCHI_OFF_IRQ_STAT: rd_d = {29'h0, irq_stat_q};
      `VCHI_OFF_IRQ_MASK: rd_d = {29'h0, irq_mask_q};
      `VCHI_OFF_BOOT_ADDR: rd_d = boot_addr_q;
      `VCHI_OFF_ENGINE_ID: rd_d = ENGINE_ID;
      `VCHI_OFF_WORK_BASE: rd_d = work_base_q;
      `VCHI_OFF_STRM_BASE: rd_d = strm_base_q;
      `VCHI_OFF_STRM_SIZE: rd_d = strm_size_q;
      `VCHI_OFF_STRM_WPTR: rd_d = strm_wptr_q;
      `VCHI_OFF_STRM_RPTR: rd_d = strm_rptr_q;
      `VCHI_OFF_FRM_BASE: rd_d = frm_base_q;
      `VCHI_OFF_GLOBAL_OPT: rd_d = global_opt_q;
      `VCHI_OFF_CMD: rd_d = {24'h0, cmd_q};
      `VCHI_OFF_CMD_INST: rd_d = {24'h0, inst_q};
      `VCHI_OFF_CMD_STD: rd_d = {29'h0, std_q};
      default: begin
        if (arg_hit) begin
          rd_d = arg_q[arg_idx];
        end
      end
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= `VCHI_RST_WORD;
    end else begin
      reg_rdata_q <= reg_rd ? rd_d : 32'h0;
    end
  end
endmodule // vchi_host_if

// File: sim/vchi_host_if_chk.sv
// Checker for the codec host command interface: port timing relations.
// Assumes it is bound to vchi_host_if with a matching FRAME_CYC.
`timescale 1ns/10ps
`include "vchi_defines.vh"
module vchi_host_if_chk #(
  parameter FRAME_CYC = 10
) (
  input wire sys_clk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata_q,
  input wire irq,
  input wire [31:0] mem_base_q,
  input wire [31:0] frm_base_q,
  input wire [2:0] codec_standard_select,
  input wire engine_busy
);
  localparam int LIM = FRAME_CYC + 8;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  sequence cmd_taken;
    $past(reg_wr && reg_addr == `VCHI_OFF_CMD);
  endsequence
  // Idle read of status, with no write that could land an event
  sequence stat_clear;
    reg_rd && reg_addr == `VCHI_OFF_IRQ_STAT && !engine_busy && !$past(reg_wr)
      && !$past(reg_wr, 2);
  endsequence
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata_q == 32'h0)
    else $error("read data not zero outside read");
  a_busy_accept: assert property ($rose(engine_busy) |-> cmd_taken)
    else $error("busy rose without command");
  // Counter, since a full frame outlasts any sensible delay range
  reg [31:0] busy_cnt_q;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt_q <= 32'h0;
    end else begin
      busy_cnt_q <= engine_busy ? busy_cnt_q + 32'h1 : 32'h0;
    end
  end
  a_busy_bound: assert property (busy_cnt_q <= LIM)
    else $error("operation did not finish");
  a_busy_min: assert property ($rose(engine_busy) |-> engine_busy [*3])
    else $error("busy too short");
  a_irq_clear: assert property (stat_clear |=> !irq)
    else $error("interrupt not cleared by read");
  a_irq_cause: assert property ($rose(irq) |-> $past(engine_busy) || $past(reg_wr)
    || $past(reg_wr, 2))
    else $error("interrupt without cause");
  a_std_cause: assert property (!$stable(codec_standard_select) |-> $past(engine_busy)
    || $past(reg_wr) || $past(reg_wr, 2))
    else $error("standard changed on its own");
  a_frm_hold: assert property (!$stable(frm_base_q)
    |-> $past(reg_wr && reg_addr == `VCHI_OFF_FRM_BASE && !engine_busy))
    else $error("frame base changed unexpectedly");
  a_work_copy: assert property (!$stable(mem_base_q)
    |-> $past(reg_wr && reg_addr == `VCHI_OFF_WORK_BASE && !engine_busy, 2))
    else $error("working base changed unexpectedly");
endmodule // vchi_host_if_chk

bind vchi_host_if vchi_host_if_chk #(.FRAME_CYC(FRAME_CYC)) u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .irq(irq),
  .mem_base_q(mem_base_q), .frm_base_q(frm_base_q),
  .codec_standard_select(codec_standard_select), .engine_busy(engine_busy));

// File: sim/vchi_host_model.sv
// Host processor model: sole master of the register port.
// Assumes callers never overlap task calls.
`timescale 1ns/10ps
`include "vchi_defines.vh"
module vchi_host_model (
  input wire sys_clk,
  input wire engine_busy,
  input wire [31:0] reg_rdata_q,
  output reg [7:0] reg_addr,
  output reg [31:0] reg_wdata,
  output reg reg_wr,
  output reg reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      // Released lines show junk, never the last value
      reg_addr <= ~a;
      reg_wdata <= ~d;
    end
  endtask
  task rd(input [7:0] a, output [31:0] d);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata_q;
    end
  endtask
  task cmd(input [7:0] inst, input [2:0] std, input [31:0] arg, input [7:0] code,
    output ok);
    integer n;
    begin
      n = 0;
      while (engine_busy !== 1'b0 && n < 40) begin
        @(posedge sys_clk);
        n = n + 1;
      end
      ok = (n < 40);
      wr(`VCHI_OFF_CMD_INST, {24'h0, inst});
      wr(`VCHI_OFF_CMD_STD, {29'h0, std});
      wr(`VCHI_OFF_ARG0, arg);
      wr(`VCHI_OFF_CMD, {24'h0, code});
    end
  endtask
endmodule // vchi_host_model

// File: sim/vchi_host_if_bench.sv
// Self-checking bench of the host command interface.
// Assumes the host model is the only master of the register port.
`timescale 1ns/10ps
`include "vchi_defines.vh"
module vchi_host_if_bench;
  localparam FC = 10;
  localparam [31:0] ID = 32'h0000_5a17; // Arbitrary identity value
  reg sys_clk;
  reg rst_n;
  wire [7:0] reg_addr;
  wire [31:0] reg_wdata, reg_rdata_q, mem_base_q, frm_base_q;
  wire reg_wr, reg_rd, irq, engine_busy;
  wire [2:0] codec_standard_select;
  integer err_count, n_compared, s;
  reg [31:0] v;
  reg ok;
  vchi_host_if #(.NINST(4), .NARG(4), .FRAME_CYC(FC), .ENGINE_ID(ID)) DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .irq(irq),
    .mem_base_q(mem_base_q), .frm_base_q(frm_base_q),
    .codec_standard_select(codec_standard_select), .engine_busy(engine_busy));
  vchi_host_model host (.sys_clk(sys_clk), .engine_busy(engine_busy),
    .reg_rdata_q(reg_rdata_q), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    begin
      $display("mismatches %0d of %0d compares", err_count, n_compared);
      if (err_count == 0 && n_compared > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        err_count = err_count + 1;
      end
    end
  endtask
  task rchk(input [7:0] a, input [31:0] m, input [31:0] exp);
    begin
      host.rd(a, v);
      chk(v & m, exp);
    end
  endtask
  // Bounded wait: a hang ends the run as a mismatch
  task wait_done;
    integer n;
    begin
      n = 0;
      #1;
      while (engine_busy !== 1'b0 && n < 40) begin
        @(posedge sys_clk);
        #1;
        n = n + 1;
      end
      if (!ok || n >= 40) begin
        err_count = err_count + 1;
        give_verdict;
      end
    end
  endtask
  task run(input [7:0] inst, input [2:0] std, input [31:0] arg, input [7:0] code);
    begin
      host.cmd(inst, std, arg, code, ok);
      wait_done;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    err_count = 0;
    n_compared = 0;
    rst_n = 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    rchk(`VCHI_OFF_STATUS, 32'hffff_ffff, 32'h0);
    rchk(`VCHI_OFF_ENGINE_ID, 32'hffff_ffff, ID);
    rchk(8'h7c, 32'hffff_ffff, 32'h0);
    host.wr(`VCHI_OFF_WORK_BASE, 32'h8000_1000);
    host.wr(`VCHI_OFF_FRM_BASE, 32'h8004_0000);
    host.wr(`VCHI_OFF_STRM_SIZE, 32'h0002_0000);
    host.wr(`VCHI_OFF_CTRL, 32'h1);
    host.wr(`VCHI_OFF_IRQ_MASK, 32'h7);
    chk(mem_base_q, 32'h8000_1000);
    chk(frm_base_q, 32'h8004_0000);
    $display("test registers done");
    for (s = 0; s < 8; s = s + 1) begin
      run(8'h0, s[2:0], 32'h1, `VCHI_CMD_OPEN);
      chk({31'h0, irq}, 32'h1);
      chk({29'h0, codec_standard_select}, s);
      rchk(`VCHI_OFF_STATUS, 32'h0001_0007, {15'h0, 1'b1, 13'h0, s == 4, 2'b0});
      rchk(`VCHI_OFF_IRQ_STAT, 32'hffff_ffff, 32'h1);
      chk({31'h0, irq}, 32'h0);
      run(8'h0, 3'h0, 32'h0, `VCHI_CMD_CLOSE);
      rchk(`VCHI_OFF_IRQ_STAT, 32'h1, 32'h1);
    end
    $display("test standards done");
    run(8'h1, 3'h2, 32'h0, `VCHI_CMD_OPEN);
    run(8'h2, 3'h5, 32'h0, `VCHI_CMD_OPEN);
    run(8'h2, 3'h0, 32'h0, `VCHI_CMD_CLOSE);
    rchk(`VCHI_OFF_STATUS, 32'h000f_0000, 32'h0002_0000);
    host.wr(`VCHI_OFF_STRM_WPTR, 32'h80);
    host.cmd(8'h1, 3'h2, 32'h0, `VCHI_CMD_PIC_RUN, ok);
    host.wr(`VCHI_OFF_FRM_BASE, 32'h1);
    host.wr(`VCHI_OFF_CMD, {24'h0, `VCHI_CMD_GET_INFO});
    wait_done;
    chk(frm_base_q, 32'h8004_0000);
    rchk(`VCHI_OFF_STRM_RPTR, 32'hffff_ffff, 32'h80);
    rchk(`VCHI_OFF_STRM_SIZE, 32'hffff_ffff, 32'h0002_0000);
    rchk(`VCHI_OFF_WORK_BASE, 32'hffff_ffff, 32'h8000_1000);
    rchk(`VCHI_OFF_IRQ_STAT, 32'h1, 32'h1);
    rchk(`VCHI_OFF_IRQ_STAT, 32'h1, 32'h0);
    $display("test picture done");
    host.wr(`VCHI_OFF_IRQ_MASK, 32'h0);
    run(8'h1, 3'h0, 32'h0, `VCHI_CMD_GET_INFO);
    chk({31'h0, irq}, 32'h0);
    rchk(`VCHI_OFF_ARG0, 32'hffff_ffff, 32'h2);
    rchk(`VCHI_OFF_ARG0 + 8'h04, 32'hffff_ffff, 32'h0002_0000);
    rchk(`VCHI_OFF_IRQ_STAT, 32'h1, 32'h1);
    run(8'h1, 3'h0, 32'h0, 8'h09);
    rchk(`VCHI_OFF_IRQ_STAT, 32'h2, 32'h2);
    $display("test mask and error done");
    rst_n <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(frm_base_q, 32'h0);
    rst_n <= 1'b1;
    rchk(`VCHI_OFF_STATUS, 32'hffff_ffff, 32'h0);
    $display("test reset done");
    give_verdict;
  end
endmodule // vchi_host_if_bench
